// *** include/irq_promote_pkg.sv ***
// Purpose: shared constants and types for the promotion, mode and
//   low-power control block
// Assumes: 20 MHz ref_clk; one 8-bit control register plus status
package irq_promote_pkg;

  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 4'h0;
  localparam logic [ADDR_W-1:0] STAT_OFFSET = 4'h1;

  localparam int BOOT_BIT = 7;
  localparam int SPECIAL_MODE_FLAG_BIT = 6;
  localparam int MDA_BIT = 5;
  localparam int IRV_BIT = 4;
  localparam int PSEL_LSB = 0;

  localparam logic [3:0] PSEL_RESET = 4'h5;
  localparam logic [3:0] PSEL_RESERVED = 4'h5;
  localparam logic [3:0] PSEL_EXT_IRQ = 4'h6;

  // fixed order of the maskable sources, highest first
  localparam logic [63:0] FIXED_ORDER = 64'h6789_ABCD_EF01_2345;

  localparam int STOP_DELAY_LONG = 4064;
  localparam int STOP_DELAY_SHORT = 4;
  localparam int DELAY_W = 12;
  localparam logic [DELAY_W-1:0] DELAY_LONG_CNT = DELAY_W'(STOP_DELAY_LONG - 1);
  localparam logic [DELAY_W-1:0] DELAY_SHORT_CNT = DELAY_W'(STOP_DELAY_SHORT - 1);
  localparam logic [1:0] LATCH_WAIT = 2'h2;

  typedef enum logic [1:0] {
    MODE_SINGLE_CHIP,
    MODE_EXPANDED,
    MODE_BOOTSTRAP,
    MODE_TEST
  } op_mode_t;

  typedef struct packed {
    logic i_mask;
    logic x_mask;
    logic stop_disable;
  } condition_flags_t;

  typedef struct packed {
    logic wait_instr;
    logic stop_instr;
  } power_instr_t;

endpackage

// *** rtl/irq_promote_mode_lowpower_ctrl.sv ***
// Purpose: interrupt promotion, operating mode latch and wait/stop control
// Assumes: requests arrive already gated by their local enables;
//   mode pins and high priority request are asynchronous pins
// Notes: all outputs registered; read data valid the cycle after rd_stb
//
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
module irq_promote_mode_lowpower_ctrl (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [irq_promote_pkg::ADDR_W-1:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rd_data,
  input wire logic mode_pin_a,
  input wire logic mode_pin_b,
  input wire irq_promote_pkg::condition_flags_t condition_flags_register,
  input wire irq_promote_pkg::power_instr_t power_instr,
  input wire logic watchdog_enable,
  input wire logic restart_delay_select,
  input wire logic [15:0] irq_requests,
  input wire logic high_pri_ext_request,
  output logic grant_valid,
  output logic [3:0] grant_source,
  output logic grant_high_pri,
  output logic stack_state,
  output logic resume_next,
  output logic core_halted,
  output logic osc_run,
  output logic timer_clk_run,
  output logic bus_clk_run,
  output logic high_addr_drive,
  output logic boot_rom_map,
  output logic internal_read_visible,
  output irq_promote_pkg::op_mode_t op_mode
);
  import irq_promote_pkg::*;

  typedef enum logic [1:0] {RUN, WAITING, STOPPED, RECOVER} power_state_t;

  logic [1:0] mode_a_sync_reg;
  logic [1:0] mode_b_sync_reg;
  logic [1:0] high_pri_ext_request_sync_reg;
  logic [1:0] latch_cnt_reg;
  logic latched_reg;
  logic special_mode_flag_reg;
  logic mode_select_a_flag_reg;
  logic boot_rom_enable_reg;
  logic irv_reg;
  logic [3:0] promotion_select_field_reg;
  power_state_t state_reg;
  power_state_t state_next;
  logic [DELAY_W-1:0] delay_cnt_reg;
  logic stop_by_high_pri_ext_request_reg;
  logic latch_now;
  logic ctrl_wr;
  logic high_pri_ext_request_req;
  logic [15:0] masked_req;
  logic irq_pending;
  logic [3:0] win_code;
  logic wake_any;

  // resolve the winning maskable source, promoted one first
  function automatic logic [3:0] pick_source(input logic [15:0] req,
                                             input logic [3:0] psel);
    logic [3:0] p;
    logic [3:0] code;
    logic found;
    p = (psel == PSEL_RESERVED) ? PSEL_EXT_IRQ : psel;
    code = p;
    found = req[p];
    for (int i = 15; i >= 0; i--)
    begin
      if (!found && req[FIXED_ORDER[i*4 +: 4]])
      begin
        code = FIXED_ORDER[i*4 +: 4];
        found = 1'b1;
      end
    end
    return code;
  endfunction

  // code 5 has no source of its own
  assign masked_req = irq_requests & ~(16'h0001 << PSEL_RESERVED);
  assign irq_pending = |masked_req;
  assign win_code = pick_source(masked_req, promotion_select_field_reg);
  assign high_pri_ext_request_req = high_pri_ext_request_sync_reg[1];
  assign latch_now = !latched_reg && (latch_cnt_reg == LATCH_WAIT);
  assign ctrl_wr = wr_stb && (addr == CTRL_OFFSET);
  assign wake_any = (irq_pending && !condition_flags_register.i_mask) ||
                    (high_pri_ext_request_req && !condition_flags_register.x_mask);

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_a_sync_reg <= 2'h0;
      mode_b_sync_reg <= 2'h0;
      high_pri_ext_request_sync_reg <= 2'h0;
    end
    else
    begin
      mode_a_sync_reg <= {mode_a_sync_reg[0], mode_pin_a};
      mode_b_sync_reg <= {mode_b_sync_reg[0], mode_pin_b};
      high_pri_ext_request_sync_reg <= {high_pri_ext_request_sync_reg[0], high_pri_ext_request};
    end
  end

  // pins are caught once the synchronisers carry post-release samples
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      latch_cnt_reg <= 2'h0;
      latched_reg <= 1'b0;
    end
    else
    begin
      if (!latched_reg && latch_cnt_reg != LATCH_WAIT)
        latch_cnt_reg <= latch_cnt_reg + 2'h1;
      if (latch_now)
        latched_reg <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      special_mode_flag_reg <= 1'b0;
      mode_select_a_flag_reg <= 1'b0;
      boot_rom_enable_reg <= 1'b0;
    end
    else if (latch_now)
    begin
      special_mode_flag_reg <= ~mode_b_sync_reg[1];
      mode_select_a_flag_reg <= mode_a_sync_reg[1];
      boot_rom_enable_reg <= ~mode_b_sync_reg[1] & ~mode_a_sync_reg[1];
    end
    else if (ctrl_wr && special_mode_flag_reg)
    begin
      special_mode_flag_reg <= wr_data[SPECIAL_MODE_FLAG_BIT];
      mode_select_a_flag_reg <= wr_data[MDA_BIT];
      boot_rom_enable_reg <= wr_data[BOOT_BIT] & wr_data[SPECIAL_MODE_FLAG_BIT];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      irv_reg <= 1'b0;
    else if (!special_mode_flag_reg)
      irv_reg <= 1'b0;
    else if (ctrl_wr)
      irv_reg <= wr_data[IRV_BIT] & wr_data[SPECIAL_MODE_FLAG_BIT];
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      promotion_select_field_reg <= PSEL_RESET;
    else if (ctrl_wr && condition_flags_register.i_mask)
      promotion_select_field_reg <= wr_data[PSEL_LSB +: 4];
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      rd_data <= 8'h00;
    else if (rd_stb && addr == CTRL_OFFSET)
      rd_data <= {boot_rom_enable_reg & special_mode_flag_reg,
                  special_mode_flag_reg, mode_select_a_flag_reg,
                  irv_reg, promotion_select_field_reg};
    else if (rd_stb && addr == STAT_OFFSET)
      rd_data <= {2'h0, state_reg, op_mode, latched_reg, high_pri_ext_request_req};
    else
      rd_data <= 8'h00;
  end

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      RUN:
      begin
        if (power_instr.wait_instr)
          state_next = WAITING;
        else if (power_instr.stop_instr &&
                 !condition_flags_register.stop_disable)
          state_next = STOPPED;
      end
      WAITING:
        if (wake_any)
          state_next = RUN;
      STOPPED:
        if ((irq_requests[PSEL_EXT_IRQ] && !condition_flags_register.i_mask)
            || high_pri_ext_request_req)
          state_next = RECOVER;
      RECOVER:
        if (delay_cnt_reg == '0)
          state_next = RUN;
    endcase
  end

  // reset always lands in RUN, fetching from the reset vector
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      state_reg <= RUN;
    else
      state_reg <= state_next;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      delay_cnt_reg <= '0;
      stop_by_high_pri_ext_request_reg <= 1'b0;
    end
    else if (state_reg == STOPPED && state_next == RECOVER)
    begin
      delay_cnt_reg <= restart_delay_select ? DELAY_LONG_CNT
                                            : DELAY_SHORT_CNT;
      stop_by_high_pri_ext_request_reg <= high_pri_ext_request_req &&
        !(irq_requests[PSEL_EXT_IRQ] && !condition_flags_register.i_mask);
    end
    else if (state_reg == RECOVER && delay_cnt_reg != '0)
      delay_cnt_reg <= delay_cnt_reg - DELAY_W'(1);
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stack_state <= 1'b0;
      resume_next <= 1'b0;
    end
    else
    begin
      stack_state <= state_reg == RUN && power_instr.wait_instr;
      resume_next <= state_reg == RECOVER && state_next == RUN &&
                     stop_by_high_pri_ext_request_reg &&
                     condition_flags_register.x_mask;
    end
  end

  // grants only outside low-power states; x mask clear services high_pri_ext_request
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      grant_valid <= 1'b0;
      grant_high_pri <= 1'b0;
      grant_source <= 4'h0;
    end
    else
    begin
      grant_high_pri <= state_next == RUN && high_pri_ext_request_req &&
                        !condition_flags_register.x_mask;
      grant_valid <= state_next == RUN && irq_pending &&
                     !condition_flags_register.i_mask;
      grant_source <= win_code;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      core_halted <= 1'b0;
      osc_run <= 1'b1;
      timer_clk_run <= 1'b1;
      bus_clk_run <= 1'b1;
    end
    else
    begin
      core_halted <= state_next != RUN;
      osc_run <= state_next != STOPPED;
      timer_clk_run <= !(state_next == STOPPED || state_next == RECOVER ||
                         (state_next == WAITING &&
                          condition_flags_register.i_mask &&
                          !watchdog_enable));
      bus_clk_run <= state_next != STOPPED &&
                     state_next != RECOVER;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      high_addr_drive <= 1'b0;
      boot_rom_map <= 1'b0;
      internal_read_visible <= 1'b0;
      op_mode <= MODE_SINGLE_CHIP;
    end
    else
    begin
      high_addr_drive <= mode_select_a_flag_reg;
      boot_rom_map <= boot_rom_enable_reg & special_mode_flag_reg;
      internal_read_visible <= irv_reg;
      op_mode <= op_mode_t'({special_mode_flag_reg,
                             mode_select_a_flag_reg});
    end
  end

endmodule
`default_nettype wire

// *** tb/irq_promote_sva.sv ***
// Purpose: port checks for the promotion, mode and power block
// Assumes: sees the top module ports only
// Notes: one clock domain, async active low reset
`timescale 1ns/1ps
`default_nettype none
module irq_promote_sva (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire irq_promote_pkg::condition_flags_t condition_flags_register,
  input wire irq_promote_pkg::power_instr_t power_instr,
  input wire logic watchdog_enable,
  input wire logic high_pri_ext_request,
  input wire logic grant_valid,
  input wire logic grant_high_pri,
  input wire logic resume_next,
  input wire logic core_halted,
  input wire logic osc_run,
  input wire logic timer_clk_run,
  input wire logic bus_clk_run,
  input wire logic boot_rom_map,
  input wire logic internal_read_visible,
  input wire irq_promote_pkg::op_mode_t op_mode
);
  import irq_promote_pkg::*;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  AST_BOOT_SPECIAL: assert property (boot_rom_map |-> op_mode[1])
    else $error("boot map outside special mode");
  AST_IRV_FORCED: assert property (!op_mode[1] |-> !internal_read_visible)
    else $error("read visibility outside special mode");
  AST_STOP_CLKS: assert property (power_instr == 2'b01 && !core_halted
    && !condition_flags_register.stop_disable
    |=> core_halted && !osc_run && !bus_clk_run)
    else $error("stop did not halt the clocks");
  AST_STOP_NOP: assert property (power_instr == 2'b01 && !core_halted
    && condition_flags_register.stop_disable |=> !core_halted)
    else $error("disabled stop halted the core");
  AST_WAIT_ENTRY: assert property (power_instr.wait_instr && !core_halted
    && condition_flags_register.i_mask && !watchdog_enable
    && !high_pri_ext_request |-> ##2 (core_halted && osc_run && !timer_clk_run))
    else $error("wait entry wrong");
  AST_BUS_CLK: assert property (!osc_run |-> !bus_clk_run)
    else $error("bus clock runs with oscillator off");
  AST_RESUME_X: assert property (resume_next |-> condition_flags_register.x_mask)
    else $error("resume with x mask clear");
  AST_HIPRI_X: assert property (grant_high_pri |-> !condition_flags_register.x_mask)
    else $error("high priority service with x mask set");
  AST_GRANT_MASK: assert property (grant_valid |-> !$past(condition_flags_register.i_mask))
    else $error("grant while i mask set");
endmodule
bind irq_promote_mode_lowpower_ctrl irq_promote_sva i_irq_promote_sva (
  .ref_clk(ref_clk), .rst_n(rst_n), .power_instr(power_instr),
  .condition_flags_register(condition_flags_register),
  .watchdog_enable(watchdog_enable), .grant_valid(grant_valid),
  .high_pri_ext_request(high_pri_ext_request), .op_mode(op_mode),
  .grant_high_pri(grant_high_pri), .resume_next(resume_next),
  .core_halted(core_halted), .osc_run(osc_run), .bus_clk_run(bus_clk_run),
  .timer_clk_run(timer_clk_run), .boot_rom_map(boot_rom_map),
  .internal_read_visible(internal_read_visible));
`default_nettype wire

// *** tb/core_side_model.sv ***
// Purpose: far side model: mode pins and high priority request pin
// Assumes: bench picks pin levels and asks for a request
// Notes: request stays up until the block reports service
`timescale 1ns/1ps
`default_nettype none
module core_side_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [1:0] mode_sel,
  input wire logic high_pri_ext_request_go,
  input wire logic serviced,
  output logic mode_pin_a,
  output logic mode_pin_b,
  output logic high_pri_ext_request
);
  // pins held steady across reset release
  always_ff @(posedge ref_clk)
  begin
    mode_pin_b <= mode_sel[1];
    mode_pin_a <= mode_sel[0];
  end
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      high_pri_ext_request <= 1'b0;
    else if (high_pri_ext_request_go)
      high_pri_ext_request <= 1'b1;
    else if (serviced)
      high_pri_ext_request <= 1'b0;
  end
endmodule
`default_nettype wire

// *** tb/irq_promote_mode_lowpower_ctrl_tb.sv ***
// Purpose: self-checking bench for the promotion, mode and power block
// Assumes: 20 MHz ref_clk, short stop recovery selected
// Notes: registers reached through the plain strobe port
`timescale 1ns/1ps
`default_nettype none
module irq_promote_mode_lowpower_ctrl_tb;
  import irq_promote_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [7:0] wr_data = '0;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  condition_flags_t condition_flags_register = 3'b111;
  power_instr_t power_instr = '0;
  logic watchdog_enable = 1'b0;
  logic restart_delay_select = 1'b0;
  logic [15:0] irq_requests = '0;
  logic [1:0] mode_sel = 2'b00;
  logic high_pri_ext_request_go = 1'b0;
  logic [7:0] rd_data;
  logic [3:0] grant_source;
  logic grant_valid, grant_high_pri, stack_state, resume_next, core_halted;
  logic osc_run, timer_clk_run, bus_clk_run, high_addr_drive, boot_rom_map;
  logic internal_read_visible, mode_pin_a, mode_pin_b, high_pri_ext_request_pin;
  op_mode_t op_mode;
  int n_fail = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #25 ref_clk = ~ref_clk;
  core_side_model i_core_side_model (.ref_clk(ref_clk), .rst_n(rst_n),
    .mode_sel(mode_sel), .high_pri_ext_request_go(high_pri_ext_request_go),
    .serviced(grant_high_pri | resume_next), .mode_pin_a(mode_pin_a),
    .mode_pin_b(mode_pin_b), .high_pri_ext_request(high_pri_ext_request_pin));
  irq_promote_mode_lowpower_ctrl i_irq_promote_mode_lowpower_ctrl (
    .ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
    .mode_pin_a(mode_pin_a), .mode_pin_b(mode_pin_b),
    .condition_flags_register(condition_flags_register),
    .power_instr(power_instr), .watchdog_enable(watchdog_enable),
    .restart_delay_select(restart_delay_select),
    .irq_requests(irq_requests), .high_pri_ext_request(high_pri_ext_request_pin),
    .grant_valid(grant_valid), .grant_source(grant_source),
    .grant_high_pri(grant_high_pri), .stack_state(stack_state),
    .resume_next(resume_next), .core_halted(core_halted),
    .osc_run(osc_run), .timer_clk_run(timer_clk_run),
    .bus_clk_run(bus_clk_run), .high_addr_drive(high_addr_drive),
    .boot_rom_map(boot_rom_map), .op_mode(op_mode),
    .internal_read_visible(internal_read_visible));
  task automatic wrap_up;
    if (n_fail == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wr_data <= d;
    wr_stb <= 1'b1;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    #1 check(rd_data, exp);
  endtask
  task automatic pulse(input power_instr_t p);
    @(posedge ref_clk);
    power_instr <= p;
    @(posedge ref_clk);
    power_instr <= '0;
  endtask
  task automatic do_reset(input logic [1:0] pins);
    mode_sel <= pins;
    rst_n <= 1'b0;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
  endtask
  // raise the request, then count cycles until the chosen answer shows
  task automatic high_pri_ext_request_wait(input logic hp, output int n);
    high_pri_ext_request_go <= 1'b1;
    @(posedge ref_clk);
    high_pri_ext_request_go <= 1'b0;
    n = 1;
    while ((hp ? grant_high_pri : resume_next) !== 1'b1 && n < 40)
    begin
      @(posedge ref_clk);
      #1 n++;
    end
  endtask
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_fail++;
      wrap_up;
    end
  end
  initial
  begin
    int n;
    do_reset(2'b00);
    rd(CTRL_OFFSET, 8'hC5);
    check({5'h0, boot_rom_map, op_mode}, 8'h06);
    condition_flags_register.i_mask <= 1'b0;
    wr(CTRL_OFFSET, 8'h73);
    rd(CTRL_OFFSET, 8'h75);
    check({5'h0, internal_read_visible, op_mode}, 8'h07);
    condition_flags_register.i_mask <= 1'b1;
    wr(CTRL_OFFSET, 8'h20);
    rd(CTRL_OFFSET, 8'h20);
    check({4'h0, boot_rom_map, high_addr_drive, op_mode}, 8'h05);
    wr(CTRL_OFFSET, 8'hD3);
    rd(CTRL_OFFSET, 8'h23);
    rd(4'h9, 8'h00);
    irq_requests <= 16'hFFFF;
    for (int c = 0; c < 16; c++)
    begin
      condition_flags_register.i_mask <= 1'b1;
      wr(CTRL_OFFSET, {4'h2, 4'(c)});
      condition_flags_register.i_mask <= 1'b0;
      repeat (3) @(posedge ref_clk);
      #1 check({grant_valid, grant_source}, {4'h1, c == 5 ? 4'h6 : 4'(c)});
    end
    irq_requests <= 16'h0081;
    repeat (3) @(posedge ref_clk);
    #1 check({3'h0, grant_valid, grant_source}, 8'h17);
    condition_flags_register.i_mask <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 check({7'h0, grant_valid}, 8'h00);
    irq_requests <= '0;
    pulse(2'b01);
    repeat (2) @(posedge ref_clk);
    #1 check({7'h0, core_halted}, 8'h00);
    condition_flags_register.stop_disable <= 1'b0;
    pulse(2'b01);
    #1 check({5'h0, core_halted, osc_run, bus_clk_run}, 8'h04);
    high_pri_ext_request_wait(1'b0, n);
    check({6'h0, resume_next, n >= 6}, 8'h03);
    // let the synchronised request drain before unmasking it
    repeat (4) @(posedge ref_clk);
    condition_flags_register.x_mask <= 1'b0;
    pulse(2'b10);
    #1 check({7'h0, stack_state}, 8'h01);
    repeat (2) @(posedge ref_clk);
    #1 check({core_halted, osc_run, timer_clk_run, bus_clk_run}, 8'h0D);
    high_pri_ext_request_wait(1'b1, n);
    check({7'h0, grant_high_pri}, 8'h01);
    pulse(2'b01);
    do_reset(2'b10);
    check({5'h0, core_halted, op_mode}, 8'h00);
    rd(CTRL_OFFSET, 8'h05);
    wr(CTRL_OFFSET, 8'hD0);
    rd(CTRL_OFFSET, 8'h00);
    wrap_up;
  end
endmodule
`default_nettype wire
